// ==== hw/uisc_pkg.sv ====
// Overview of operation
// - low divisor byte is write-only, 8 bits, cleared by power-on reset only
// - enable and identification registers reachable only with divisor latch bit zero
// - enable bit 7 allows cts/dsr change, bit 6 allows rts/dtr change interrupt
// - enable bit 5 allows software flow control (xoff or special char) interrupt
// - enable bit 4 enables sleep, effective only with enhanced functions enabled
// - sleep entry needs no pending interrupt, steady modem, rx high, fifos empty
// - sleep exits on modem toggle, rx pin low, or transmit fifo write
// - while asleep uart_clk_enable is low so no uart clock runs; ref_clk keeps running
// - enable bit 3 allows the modem status interrupt
// - enable bit 2 allows the receiver line status error interrupt
// - enable bit 1: tx ready on empty holding register, or spaces above trigger
// - enable bit 0 allows the receive data ready interrupt
// - writes to enable bits 7..4 ignored unless enhanced functions enabled
// - identification bit 0 is one when nothing pending; resets to 0x01
// - codes: line error 06, timeout 0c, rx data 04, tx ready 02, modem 00
// - codes: pin change 30, xoff/special 10, flow line inactive 20
// - bit 4 clears on xon after xoff, or on identification read after special char
// - low divisor byte at shared offset only with latch bit one and line control not 0xbf
// - enhanced enable gates upper enable bits, identification bits 5:4, and sleep
package uisc_pkg;

  localparam int unsigned UISC_ADDR_W = 4;
  localparam int unsigned UISC_DATA_W = 8;
  localparam int unsigned UISC_MODEM_W = 4;
  localparam int unsigned UISC_SPACE_W = 7;

  // register offsets; offset 1 also holds the high divisor byte when the latch bit is set and line control is not 0xbf
  localparam logic [3:0] UISC_OFS_HOLD_DLO = 4'h0;
  localparam logic [3:0] UISC_OFS_IEN_DHI = 4'h1;
  localparam logic [3:0] UISC_OFS_IID = 4'h2;

  localparam logic [7:0] UISC_IEN_RESET = 8'h00;
  localparam logic [7:0] UISC_IID_RESET = 8'h01;
  localparam logic [7:0] UISC_DIV_RESET = 8'h00;
  localparam logic [7:0] UISC_RDATA_RESET = 8'h00;
  localparam logic [7:0] UISC_LCR_EFR_KEY = 8'hbf;
  localparam int unsigned UISC_DLAB_POS = 7;

  // interrupt enable field positions
  localparam int unsigned UISC_IEN_CTS_DSR = 7;
  localparam int unsigned UISC_IEN_RTS_DTR = 6;
  localparam int unsigned UISC_IEN_SWFLOW = 5;
  localparam int unsigned UISC_IEN_SLEEP = 4;
  localparam int unsigned UISC_IEN_MODEM = 3;
  localparam int unsigned UISC_IEN_LINE = 2;
  localparam int unsigned UISC_IEN_TXRDY = 1;
  localparam int unsigned UISC_IEN_RXRDY = 0;
  localparam logic [7:0] UISC_IEN_UPPER_MASK = 8'hf0;

  // identification bits 5..0, bit 0 low means pending
  localparam logic [5:0] UISC_ID_LINE_ERR = 6'h06;
  localparam logic [5:0] UISC_ID_RX_TIMEOUT = 6'h0c;
  localparam logic [5:0] UISC_ID_RX_DATA = 6'h04;
  localparam logic [5:0] UISC_ID_TX_READY = 6'h02;
  localparam logic [5:0] UISC_ID_MODEM = 6'h00;
  localparam logic [5:0] UISC_ID_PIN_CHANGE = 6'h30;
  localparam logic [5:0] UISC_ID_SWFLOW = 6'h10;
  localparam logic [5:0] UISC_ID_FLOW_LINE = 6'h20;
  localparam logic [5:0] UISC_ID_NONE = 6'h01;

  typedef enum logic [0:0] {
    UISC_AWAKE = 1'b0,
    UISC_ASLEEP = 1'b1
  } uisc_sleep_state_t;

endpackage : uisc_pkg

// ==== hw/uisc_sleep_ctrl.sv ====
`timescale 1ns/1ns
module uisc_sleep_ctrl
  import uisc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic sleep_allowed,
  input wire logic idle_conditions,
  input wire logic wake_event,
  output logic sleep_active,
  output logic uart_clk_enable
);

  typedef struct packed {
    uisc_sleep_state_t state;
    logic clk_en;
  } uisc_sleep_regs_t;

  uisc_sleep_regs_t st_reg;
  uisc_sleep_regs_t st_next;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg.state)
      UISC_AWAKE: begin
        if (sleep_allowed && idle_conditions && !wake_event) begin
          st_next.state = UISC_ASLEEP;
        end
      end
      UISC_ASLEEP: begin
        // dropping the enable also ends sleep so software can never strand the channel
        if (wake_event || !sleep_allowed) begin
          st_next.state = UISC_AWAKE;
        end
      end
    endcase
    if (soft_reset) begin
      st_next.state = UISC_AWAKE;
    end
    st_next.clk_en = (st_next.state == UISC_AWAKE);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{state: UISC_AWAKE, clk_en: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sleep_active = (st_reg.state == UISC_ASLEEP);
  assign uart_clk_enable = st_reg.clk_en;

endmodule : uisc_sleep_ctrl

// ==== hw/uisc_channel.sv ====
`timescale 1ns/1ns
module uisc_channel
  import uisc_pkg::*;
#(
  parameter int unsigned MODEM_W = UISC_MODEM_W,
  parameter int unsigned SPACE_W = UISC_SPACE_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic [UISC_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [UISC_DATA_W-1:0] reg_wdata,
  input wire logic [UISC_DATA_W-1:0] line_control,
  input wire logic enhanced_function_enable,
  input wire logic fifo_enable_bit,
  input wire logic thr_empty,
  input wire logic [SPACE_W-1:0] tx_fifo_space,
  input wire logic [SPACE_W-1:0] tx_trigger_spaces,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_empty,
  input wire logic line_status_error,
  input wire logic rx_timeout,
  input wire logic rx_data_ready,
  input wire logic modem_status_change,
  input wire logic pin_change,
  input wire logic xoff_detect,
  input wire logic xon_detect,
  input wire logic special_char_detect,
  input wire logic cts_dsr_change,
  input wire logic rts_dtr_change,
  input wire logic [MODEM_W-1:0] modem_in,
  input wire logic rx_pin,
  output logic [UISC_DATA_W-1:0] reg_rdata,
  output logic interrupt_pending,
  output logic [UISC_DATA_W-1:0] baud_divisor_low,
  output logic [UISC_DATA_W-1:0] baud_divisor_high,
  output logic sleep_active,
  output logic uart_clk_enable
);

  typedef struct packed {
    logic [7:0] ien;
    logic [7:0] iid;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] rdata;
    logic pending;
    logic xoff_flag;
    logic special_flag;
    logic [MODEM_W-1:0] modem_meta;
    logic [MODEM_W-1:0] modem_sync;
    logic [MODEM_W-1:0] modem_prev;
    logic rx_meta;
    logic rx_sync;
  } uisc_chan_regs_t;

  uisc_chan_regs_t st_reg;
  uisc_chan_regs_t st_next;

  // access decode
  logic dlab;
  logic efr_key;
  logic hit_ien;
  logic hit_iid;
  logic hit_dlo;
  logic hit_dhi;
  logic hit_thr;
  logic wr_ien;
  logic wr_dlo;
  logic wr_dhi;
  logic rd_iid;
  logic thr_load;

  // interrupt sources after enable gating
  logic tx_ready_raw;
  logic en_line;
  logic en_timeout;
  logic en_rxdata;
  logic en_txrdy;
  logic en_modem;
  logic en_pin;
  logic en_swflow;
  logic en_flowline;
  logic any_enabled;
  logic [5:0] id_code;

  // sleep handshake
  logic modem_toggle;
  logic rx_idle_high;
  logic sleep_allowed;
  logic idle_conditions;
  logic wake_event;
  logic sleep_q;
  logic clk_en_q;

  always_comb begin
    dlab = line_control[UISC_DLAB_POS];
    efr_key = (line_control == UISC_LCR_EFR_KEY);
    hit_ien = (reg_addr == UISC_OFS_IEN_DHI) && !dlab;
    hit_iid = (reg_addr == UISC_OFS_IID) && !dlab;
    hit_dlo = (reg_addr == UISC_OFS_HOLD_DLO) && dlab && !efr_key;
    hit_dhi = (reg_addr == UISC_OFS_IEN_DHI) && dlab && !efr_key;
    hit_thr = (reg_addr == UISC_OFS_HOLD_DLO) && !dlab;
    wr_ien = reg_wr && hit_ien;
    wr_dlo = reg_wr && hit_dlo;
    wr_dhi = reg_wr && hit_dhi;
    rd_iid = reg_rd && hit_iid;
    thr_load = reg_wr && hit_thr;
  end

  always_comb begin
    // fifo mode compares free space to the trigger, character mode uses the holding flag
    if (fifo_enable_bit) begin
      tx_ready_raw = (tx_fifo_space > tx_trigger_spaces);
    end else begin
      tx_ready_raw = thr_empty;
    end
    en_line = line_status_error && st_reg.ien[UISC_IEN_LINE];
    en_timeout = rx_timeout && st_reg.ien[UISC_IEN_RXRDY];
    en_rxdata = rx_data_ready && st_reg.ien[UISC_IEN_RXRDY];
    en_txrdy = tx_ready_raw && st_reg.ien[UISC_IEN_TXRDY];
    en_modem = modem_status_change && st_reg.ien[UISC_IEN_MODEM];
    // the sources reported in bits 5:4 exist only with enhanced functions on
    en_pin = pin_change && st_reg.ien[UISC_IEN_MODEM] && enhanced_function_enable;
    en_swflow = (st_reg.xoff_flag || st_reg.special_flag) && st_reg.ien[UISC_IEN_SWFLOW]
                && enhanced_function_enable;
    en_flowline = ((cts_dsr_change && st_reg.ien[UISC_IEN_CTS_DSR])
                || (rts_dtr_change && st_reg.ien[UISC_IEN_RTS_DTR]))
                && enhanced_function_enable;
    any_enabled = en_line || en_timeout || en_rxdata || en_txrdy || en_modem
                || en_pin || en_swflow || en_flowline;
  end

  // fixed priority: first match wins, timeout ahead of data at the same level
  always_comb begin
    if (en_line) begin
      id_code = UISC_ID_LINE_ERR;
    end else if (en_timeout) begin
      id_code = UISC_ID_RX_TIMEOUT;
    end else if (en_rxdata) begin
      id_code = UISC_ID_RX_DATA;
    end else if (en_txrdy) begin
      id_code = UISC_ID_TX_READY;
    end else if (en_modem) begin
      id_code = UISC_ID_MODEM;
    end else if (en_pin) begin
      id_code = UISC_ID_PIN_CHANGE;
    end else if (en_swflow) begin
      id_code = UISC_ID_SWFLOW;
    end else if (en_flowline) begin
      id_code = UISC_ID_FLOW_LINE;
    end else begin
      id_code = UISC_ID_NONE;
    end
  end

  always_comb begin
    modem_toggle = (st_reg.modem_sync != st_reg.modem_prev);
    rx_idle_high = st_reg.rx_sync;
    sleep_allowed = st_reg.ien[UISC_IEN_SLEEP] && enhanced_function_enable;
    // the live source term closes the gap before the pending flop catches up
    idle_conditions = !st_reg.pending && !any_enabled && !modem_toggle && rx_idle_high
                    && tx_fifo_empty && rx_fifo_empty;
    wake_event = modem_toggle || !rx_idle_high || thr_load;
  end

  uisc_sleep_ctrl u_sleep (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .soft_reset(soft_reset),
    .sleep_allowed(sleep_allowed),
    .idle_conditions(idle_conditions),
    .wake_event(wake_event),
    .sleep_active(sleep_q),
    .uart_clk_enable(clk_en_q)
  );

  always_comb begin
    st_next = st_reg;

    // pins from outside pass two flops before anything looks at them
    st_next.modem_meta = modem_in;
    st_next.modem_sync = st_reg.modem_meta;
    st_next.modem_prev = st_reg.modem_sync;
    st_next.rx_meta = rx_pin;
    st_next.rx_sync = st_reg.rx_meta;

    if (wr_ien) begin
      if (enhanced_function_enable) begin
        st_next.ien = reg_wdata;
      end else begin
        // upper bits keep their value, only the classic lower nibble is written
        st_next.ien = (st_reg.ien & UISC_IEN_UPPER_MASK)
                    | (reg_wdata & ~UISC_IEN_UPPER_MASK);
      end
    end

    if (wr_dlo) begin
      st_next.div_low = reg_wdata;
    end
    if (wr_dhi) begin
      st_next.div_high = reg_wdata;
    end

    // xoff flag: set by xoff, cleared by xon; a simultaneous xoff wins
    if (xoff_detect) begin
      st_next.xoff_flag = 1'b1;
    end else if (xon_detect) begin
      st_next.xoff_flag = 1'b0;
    end

    // special char flag: set by detection, cleared by reading identification
    if (special_char_detect) begin
      st_next.special_flag = 1'b1;
    end else if (rd_iid) begin
      st_next.special_flag = 1'b0;
    end

    // the identification word is rebuilt every cycle from live sources
    st_next.iid = {fifo_enable_bit, fifo_enable_bit, id_code};
    st_next.pending = any_enabled;

    if (reg_rd) begin
      if (hit_iid) begin
        st_next.rdata = st_reg.iid;
      end else if (hit_ien) begin
        st_next.rdata = st_reg.ien;
      end else if (hit_dhi) begin
        st_next.rdata = st_reg.div_high;
      end else begin
        // low divisor is write-only and unmapped offsets read zero
        st_next.rdata = UISC_RDATA_RESET;
      end
    end

    // software reset spares the divisor bytes, which only power-on clears
    if (soft_reset) begin
      st_next.ien = UISC_IEN_RESET;
      st_next.iid = UISC_IID_RESET;
      st_next.pending = 1'b0;
      st_next.xoff_flag = 1'b0;
      st_next.special_flag = 1'b0;
      st_next.rdata = UISC_RDATA_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.ien <= UISC_IEN_RESET;
      st_reg.iid <= UISC_IID_RESET;
      st_reg.div_low <= UISC_DIV_RESET;
      st_reg.div_high <= UISC_DIV_RESET;
      st_reg.rdata <= UISC_RDATA_RESET;
      st_reg.pending <= 1'b0;
      st_reg.xoff_flag <= 1'b0;
      st_reg.special_flag <= 1'b0;
      // modem pins idle high, so reset ones avoid a false toggle and wake
      st_reg.modem_meta <= '1;
      st_reg.modem_sync <= '1;
      st_reg.modem_prev <= '1;
      // rx idles high, so a reset value of one avoids a false wake
      st_reg.rx_meta <= 1'b1;
      st_reg.rx_sync <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign interrupt_pending = st_reg.pending;
  assign baud_divisor_low = st_reg.div_low;
  assign baud_divisor_high = st_reg.div_high;
  assign sleep_active = sleep_q;
  assign uart_clk_enable = clk_en_q;

endmodule : uisc_channel

// ==== verification/uisc_chk.sv ====
`timescale 1ns/1ns
module uisc_chk
  import uisc_pkg::*;
#(
  parameter int unsigned SPACE_W = UISC_SPACE_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic [UISC_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [UISC_DATA_W-1:0] reg_wdata,
  input wire logic [UISC_DATA_W-1:0] line_control,
  input wire logic enhanced_function_enable,
  input wire logic fifo_enable_bit,
  input wire logic thr_empty,
  input wire logic [SPACE_W-1:0] tx_fifo_space,
  input wire logic [SPACE_W-1:0] tx_trigger_spaces,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_empty,
  input wire logic rx_data_ready,
  input wire logic [UISC_DATA_W-1:0] reg_rdata,
  input wire logic interrupt_pending,
  input wire logic [UISC_DATA_W-1:0] baud_divisor_low,
  input wire logic [UISC_DATA_W-1:0] baud_divisor_high,
  input wire logic sleep_active,
  input wire logic uart_clk_enable
);
  logic [7:0] ien_reg;
  logic can_sleep;
  // shadow of the enable register, so source checks know what is permitted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      ien_reg <= 8'h00;
    else if (soft_reset)
      ien_reg <= 8'h00;
    else if (reg_wr && reg_addr == UISC_OFS_IEN_DHI && !line_control[7])
      ien_reg <= enhanced_function_enable ? reg_wdata : {ien_reg[7:4], reg_wdata[3:0]};
  end
  assign can_sleep = ien_reg[4] && enhanced_function_enable && !interrupt_pending &&
    tx_fifo_empty && rx_fifo_empty;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_stay_awake;
    !sleep_active && !can_sleep;
  endsequence
  sequence s_wake_write;
    sleep_active && reg_wr && reg_addr == UISC_OFS_HOLD_DLO && !line_control[7];
  endsequence
  property p_id_read;
    reg_rd && reg_addr == UISC_OFS_IID && !line_control[7] && !soft_reset &&
      $stable(fifo_enable_bit) |=> reg_rdata[0] == !$past(interrupt_pending) &&
      reg_rdata[7:6] == {2{$past(fifo_enable_bit)}};
  endproperty
  property p_rx;
    ien_reg[0] && rx_data_ready && !soft_reset |=> interrupt_pending;
  endproperty
  property p_tx;
    ien_reg[1] && !soft_reset &&
      (fifo_enable_bit ? tx_fifo_space > tx_trigger_spaces : thr_empty) |=> interrupt_pending;
  endproperty
  property p_none;
    ien_reg == 8'h00 |=> !interrupt_pending;
  endproperty
  property p_dhi;
    reg_wr && reg_addr == UISC_OFS_IEN_DHI && line_control[7] &&
      line_control != UISC_LCR_EFR_KEY |=> baud_divisor_high == $past(reg_wdata);
  endproperty
  property p_bf;
    reg_wr && reg_addr == UISC_OFS_HOLD_DLO && line_control == UISC_LCR_EFR_KEY
      |=> $stable(baud_divisor_low);
  endproperty
  property p_soft;
    soft_reset && !reg_wr |=> $stable(baud_divisor_low) && $stable(baud_divisor_high);
  endproperty
  property p_sleep_in;
    s_stay_awake |=> !sleep_active;
  endproperty
  property p_wake;
    s_wake_write |=> !sleep_active;
  endproperty
  property p_clk;
    uart_clk_enable != sleep_active;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("id read disagrees with pending flag");
  a_rx: assert property (p_rx)
    else $error("rx data not reported");
  a_tx: assert property (p_tx)
    else $error("tx ready not reported");
  a_none: assert property (p_none)
    else $error("pending with all sources disabled");
  a_dhi: assert property (p_dhi)
    else $error("high divisor not written");
  a_bf: assert property (p_bf)
    else $error("low divisor written under key value");
  a_soft: assert property (p_soft)
    else $error("divisor changed by soft reset");
  a_sleep_in: assert property (p_sleep_in)
    else $error("sleep entered without conditions");
  a_wake: assert property (p_wake)
    else $error("no wake on transmit write");
  a_clk: assert property (p_clk)
    else $error("clock enable not inverse of sleep");
endmodule : uisc_chk

bind uisc_channel uisc_chk #(.SPACE_W(SPACE_W)) i_chk (.ref_clk, .rst_n, .soft_reset,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .line_control, .enhanced_function_enable,
  .fifo_enable_bit, .thr_empty, .tx_fifo_space, .tx_trigger_spaces, .tx_fifo_empty,
  .rx_fifo_empty, .rx_data_ready, .reg_rdata, .interrupt_pending, .baud_divisor_low,
  .baud_divisor_high, .sleep_active, .uart_clk_enable);

// ==== verification/uisc_host.sv ====
`timescale 1ns/1ns
module uisc_host (
  input wire logic ref_clk,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // idle lines flip to the inverse so a stale byte is never mistaken for a held one
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : uisc_host

// ==== verification/uisc_channel_tb.sv ====
`timescale 1ns/1ns
module uisc_channel_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic [7:0] line_control = 8'h00;
  logic enhanced_function_enable = 1'b0;
  logic fifo_enable_bit = 1'b0;
  logic [6:0] tx_fifo_space = 7'h00;
  logic [6:0] tx_trigger_spaces = 7'h00;
  logic tx_fifo_empty = 1'b0;
  logic rx_fifo_empty = 1'b0;
  logic [7:0] src = 8'h00;
  logic xoff_detect = 1'b0;
  logic xon_detect = 1'b0;
  logic special_char_detect = 1'b0;
  logic rx_pin = 1'b1;
  logic [3:0] modem_in = 4'hf;
  logic [3:0] reg_addr;
  logic reg_wr, reg_rd, interrupt_pending, sleep_active, uart_clk_enable;
  logic [7:0] reg_wdata, reg_rdata, baud_divisor_low, baud_divisor_high;
  int miscompares = 0;
  int check_count = 0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hd2d2;
  logic [7:0] d0, d1;
  logic [5:0] codes [8] = '{6'h06, 6'h0c, 6'h04, 6'h02, 6'h00, 6'h30, 6'h10, 6'h20};

  always #50 ref_clk = ~ref_clk;

  uisc_host i_host (.ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  uisc_channel i_dut (.ref_clk, .rst_n, .soft_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .line_control, .enhanced_function_enable, .fifo_enable_bit, .thr_empty(src[3]),
    .tx_fifo_space, .tx_trigger_spaces, .tx_fifo_empty, .rx_fifo_empty,
    .line_status_error(src[0]), .rx_timeout(src[1]), .rx_data_ready(src[2]),
    .modem_status_change(src[4]), .pin_change(src[5]), .xoff_detect, .xon_detect,
    .special_char_detect, .cts_dsr_change(src[7]), .rts_dtr_change(src[6]), .modem_in,
    .rx_pin, .reg_rdata, .interrupt_pending, .baud_divisor_low, .baud_divisor_high,
    .sleep_active, .uart_clk_enable);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic chk8(input logic [7:0] e, input logic [7:0] a);
    check_count++;
    if (a !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t byte exp %h got %h", $time, e, a);
    end
  endtask : chk8
  task automatic chk1(input logic e, input logic a);
    check_count++;
    if (a !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t flag exp %b got %b", $time, e, a);
    end
  endtask : chk1
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask : rd
  task automatic pulse(ref logic p);
    p = 1'b1;
    cyc(1);
    p = 1'b0;
    cyc(2);
  endtask : pulse
  task automatic summarize;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // read data lands one edge after the strobe
  always @(posedge ref_clk) begin
    if (reg_rd) begin
      @(negedge ref_clk);
      chk8(exp_q.pop_front(), reg_rdata);
    end
  end

  initial begin
    #300000;
    miscompares++;
    summarize();
  end

  initial begin
    cyc(12);
    rst_n = 1'b1;
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h01);
    $display("test reset done");
    enhanced_function_enable = 1'b1;
    i_host.wr(4'h1, 8'hef);
    // each step adds a higher source, so the newest one must win
    for (int k = 7; k >= 0; k--) begin
      if (k == 6)
        pulse(xoff_detect);
      else begin
        src[k] = 1'b1;
        cyc(3);
      end
      rd(4'h2, {2'b00, codes[k]});
    end
    src[5:0] = 6'h00;
    cyc(2);
    rd(4'h2, 8'h10);
    pulse(xon_detect);
    rd(4'h2, 8'h20);
    pulse(special_char_detect);
    rd(4'h2, 8'h10);
    cyc(2);
    rd(4'h2, 8'h20);
    src[7] = 1'b0;
    src[6] = 1'b1;
    cyc(3);
    rd(4'h2, 8'h20);
    enhanced_function_enable = 1'b0;
    cyc(3);
    rd(4'h2, 8'h01);
    src[6] = 1'b0;
    enhanced_function_enable = 1'b1;
    fifo_enable_bit = 1'b1;
    i_host.wr(4'h1, 8'h02);
    tx_fifo_space = 7'h10;
    tx_trigger_spaces = 7'h10;
    cyc(3);
    chk1(1'b0, interrupt_pending);
    tx_fifo_space = 7'h11;
    cyc(2);
    rd(4'h2, 8'hc2);
    fifo_enable_bit = 1'b0;
    enhanced_function_enable = 1'b0;
    i_host.wr(4'h1, 8'hff);
    rd(4'h1, 8'h0f);
    i_host.wr(4'h1, 8'h0e);
    src[2] = 1'b1;
    cyc(3);
    chk1(1'b0, interrupt_pending);
    src[2] = 1'b0;
    $display("test irq done");
    line_control = 8'h80;
    seed = xs(seed);
    d0 = seed[7:0];
    d1 = seed[15:8];
    i_host.wr(4'h0, d0);
    i_host.wr(4'h1, d1);
    chk8(d0, baud_divisor_low);
    rd(4'h1, d1);
    rd(4'h0, 8'h00);
    line_control = 8'hbf;
    i_host.wr(4'h0, ~d0);
    chk8(d0, baud_divisor_low);
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    chk8(d0, baud_divisor_low);
    chk8(d1, baud_divisor_high);
    line_control = 8'h00;
    rd(4'h1, 8'h00);
    $display("test divisor done");
    enhanced_function_enable = 1'b1;
    i_host.wr(4'h1, 8'h10);
    cyc(3);
    chk1(1'b0, sleep_active);
    tx_fifo_empty = 1'b1;
    rx_fifo_empty = 1'b1;
    cyc(3);
    chk1(1'b1, sleep_active);
    chk1(1'b0, uart_clk_enable);
    i_host.wr(4'h0, seed[23:16]);
    chk1(1'b0, sleep_active);
    cyc(2);
    chk1(1'b1, sleep_active);
    rx_pin = 1'b0;
    cyc(4);
    chk1(1'b0, sleep_active);
    chk1(1'b1, uart_clk_enable);
    rx_pin = 1'b1;
    cyc(4);
    chk1(1'b1, sleep_active);
    // a modem toggle wakes for one decision only, so look right after the wake edge
    modem_in = 4'he;
    cyc(3);
    chk1(1'b0, sleep_active);
    enhanced_function_enable = 1'b0;
    cyc(3);
    chk1(1'b0, sleep_active);
    $display("test sleep done");
    cyc(2);
    summarize();
  end
endmodule : uisc_channel_tb
